// >>> hw/tmwf_timer.sv
// Operation
// RULE_01 - counter synchronous, tick is enable only
// RULE_02 - bottom events mirror top event timing
// RULE_03 - nonzero action field overrides port pin
// RULE_04 - pad driven only when direction is output
// RULE_05 - non-pwm actions: off, toggle, clear, set
// RULE_06 - fast pwm: clear/set on match, bottom
// RULE_07 - fast pwm toggle A only modes 14/15
// RULE_08 - fast pwm compare at top ignored
// RULE_09 - dual-slope toggle A only modes 9/11
// RULE_10 - dual-slope: direction decides set or clear
// RULE_11 - mode low bits A, high bits B
// RULE_12 - normal and clear-on-match top and timing
// RULE_13 - phase correct tops, load top, flag bottom
// RULE_14 - fast pwm tops, load bottom, flag top
// RULE_15 - phase-frequency modes load and flag bottom
// RULE_16 - clock selector: stop, dividers, external edges
// RULE_17 - compare match sets channel flag
// RULE_18 - control A bits 3:2 read zero
`timescale 1ns/1ps
`default_nettype none
`include "tmwf_consts.svh"
module tmwf_timer
  import tmwf_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_clock_pin,
  input wire logic [1:0] port_out,
  output logic [1:0] pad_out,
  output logic [1:0] pad_oe,
  output logic irq
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [7:0] waveform_control_a;
  logic [7:0] waveform_control_b;
  logic [15:0] counter_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] cmp_buf_a;
  logic [15:0] cmp_buf_b;
  logic [15:0] capture_value;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [1:0] pin_dir;
  logic count_down;
  logic wave_out_a;
  logic wave_out_b;
  logic [9:0] prescale;
  logic [2:0] ext_sync;
  logic timer_tick_enable;
  logic [3:0] wave_mode_sel;
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  logic [2:0] prescale_sel;
  logic [15:0] top_value;
  tmwf_family_t family;
  logic at_top;
  logic at_bottom;
  logic load_now;
  logic ovf_event;
  logic match_a;
  logic match_b;
  logic [15:0] next_counter;
  logic next_down;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic wr_cnt;
  logic [2:0] irq_clr;
  logic [1:0] next_wave;
  logic [1:0] chan_match;
  logic [1:0] chan_ovr;

  // reset release through two flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // mode selector assembly
  assign wave_mode_sel = {waveform_control_b[4:3], waveform_control_a[1:0]}; // RULE_11
  assign output_action_a = waveform_control_a[7:6];
  assign output_action_b = waveform_control_a[5:4];
  assign prescale_sel = waveform_control_b[2:0];

  // top source, load point and flag point per mode
  always_comb
  begin
    top_value = `TMWF_MAX;
    family = TMWF_NORMAL;
    case (wave_mode_sel)
      4'h0: top_value = `TMWF_MAX; // RULE_12
      4'h1: begin top_value = `TMWF_TOP_8; family = TMWF_DUAL_TOPLOAD; end // RULE_13
      4'h2: begin top_value = `TMWF_TOP_9; family = TMWF_DUAL_TOPLOAD; end
      4'h3: begin top_value = `TMWF_TOP_10; family = TMWF_DUAL_TOPLOAD; end
      4'h4: top_value = compare_value_a; // RULE_12
      4'h5: begin top_value = `TMWF_TOP_8; family = TMWF_FAST; end // RULE_14
      4'h6: begin top_value = `TMWF_TOP_9; family = TMWF_FAST; end
      4'h7: begin top_value = `TMWF_TOP_10; family = TMWF_FAST; end
      4'h8: begin top_value = capture_value; family = TMWF_DUAL_BOTLOAD; end // RULE_15
      4'h9: begin top_value = compare_value_a; family = TMWF_DUAL_BOTLOAD; end
      4'hA: begin top_value = capture_value; family = TMWF_DUAL_TOPLOAD; end // RULE_13
      4'hB: begin top_value = compare_value_a; family = TMWF_DUAL_TOPLOAD; end
      4'hC: top_value = capture_value; // RULE_12
      4'hE: begin top_value = capture_value; family = TMWF_FAST; end // RULE_14
      4'hF: begin top_value = compare_value_a; family = TMWF_FAST; end
      default: top_value = `TMWF_MAX; // reserved mode 13 runs as normal
    endcase
  end

  assign at_top = (counter_value == top_value);
  assign at_bottom = (counter_value == `TMWF_BOTTOM);

  // load and overflow fire on the tick that leaves top or bottom, so bottom mirrors top
  always_comb
  begin
    load_now = 1'b0;
    ovf_event = 1'b0;
    case (family)
      TMWF_NORMAL: ovf_event = timer_tick_enable && (counter_value == `TMWF_MAX);
      TMWF_FAST:
      begin
        load_now = timer_tick_enable && at_top; // RULE_14
        ovf_event = timer_tick_enable && at_top;
      end
      TMWF_DUAL_TOPLOAD:
      begin
        load_now = timer_tick_enable && at_top && !count_down; // RULE_13
        ovf_event = timer_tick_enable && at_bottom && count_down; // RULE_02
      end
      TMWF_DUAL_BOTLOAD:
      begin
        load_now = timer_tick_enable && at_bottom && count_down; // RULE_15 RULE_02
        ovf_event = timer_tick_enable && at_bottom && count_down;
      end
      default: ovf_event = 1'b0;
    endcase
  end

  // prescaler and external edge detection, all enables on one clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= 10'h000;
    else if (prescale_sel == 3'h0)
      prescale <= 10'h000;
    else
      prescale <= prescale + 10'h001;
  end

  // pin synchroniser; only the later stages feed the edge detector
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ext_sync <= 3'h0;
    else
      ext_sync <= {ext_sync[1:0], ext_clock_pin};
  end

  always_comb
  begin
    case (prescale_sel) // RULE_16
      3'h0: timer_tick_enable = 1'b0;
      3'h1: timer_tick_enable = 1'b1;
      3'h2: timer_tick_enable = ((prescale & `TMWF_DIV8_MASK) == `TMWF_DIV8_MASK);
      3'h3: timer_tick_enable = ((prescale & `TMWF_DIV64_MASK) == `TMWF_DIV64_MASK);
      3'h4: timer_tick_enable = ((prescale & `TMWF_DIV256_MASK) == `TMWF_DIV256_MASK);
      3'h5: timer_tick_enable = (prescale == `TMWF_DIV1024_MASK);
      3'h6: timer_tick_enable = ext_sync[2] && !ext_sync[1];
      default: timer_tick_enable = !ext_sync[2] && ext_sync[1];
    endcase
  end

  // next count and direction
  always_comb
  begin
    next_counter = counter_value;
    next_down = count_down;
    if (family == TMWF_DUAL_TOPLOAD || family == TMWF_DUAL_BOTLOAD)
    begin
      if (!count_down && at_top)
      begin
        next_down = 1'b1;
        next_counter = counter_value - 16'h0001;
      end
      else if (count_down && at_bottom)
      begin
        next_down = 1'b0;
        next_counter = counter_value + 16'h0001;
      end
      else if (count_down)
        next_counter = counter_value - 16'h0001;
      else
        next_counter = counter_value + 16'h0001;
    end
    else if (at_top)
    begin
      next_counter = `TMWF_BOTTOM;
      next_down = 1'b0;
    end
    else
    begin
      next_counter = counter_value + 16'h0001;
      next_down = 1'b0;
    end
  end

  // counter runs on the system clock, tick only qualifies it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_value <= 16'h0000;
      count_down <= 1'b0;
    end
    else if (wr_cnt)
      counter_value <= hwdata[15:0];
    else if (timer_tick_enable) // RULE_01
    begin
      counter_value <= next_counter;
      count_down <= next_down;
    end
  end

  // channel compare match, suppressed in fast pwm at top when upper action bit set; flag matches are never suppressed
  assign chan_match[0] = timer_tick_enable && (counter_value == compare_value_a) &&
    !(family == TMWF_FAST && at_top && output_action_a[1]); // RULE_08
  assign chan_match[1] = timer_tick_enable && (counter_value == compare_value_b) &&
    !(family == TMWF_FAST && at_top && output_action_b[1]); // RULE_08
  assign match_a = timer_tick_enable && (counter_value == compare_value_a);
  assign match_b = timer_tick_enable && (counter_value == compare_value_b);

  // per-channel waveform logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [1:0] act;
      logic cur;
      assign act = (ch == 0) ? output_action_a : output_action_b;
      assign cur = (ch == 0) ? wave_out_a : wave_out_b;
      always_comb
      begin
        next_wave[ch] = cur;
        chan_ovr[ch] = (act != 2'h0); // RULE_03
        case (family)
          TMWF_NORMAL:
          begin
            if (chan_match[ch])
              case (act) // RULE_05
                2'h1: next_wave[ch] = !cur;
                2'h2: next_wave[ch] = 1'b0;
                2'h3: next_wave[ch] = 1'b1;
                default: next_wave[ch] = cur;
              endcase
          end
          TMWF_FAST:
          begin
            if (act == 2'h1)
            begin
              chan_ovr[ch] = (ch == 0) && wave_mode_sel[3:1] == 3'h7; // RULE_07
              if (chan_ovr[ch] && chan_match[ch])
                next_wave[ch] = !cur;
            end
            else if (act[1] && timer_tick_enable && at_top)
              next_wave[ch] = !act[0]; // RULE_06
            else if (act[1] && chan_match[ch])
              next_wave[ch] = act[0]; // RULE_06
          end
          default:
          begin
            if (act == 2'h1)
            begin
              chan_ovr[ch] = (ch == 0) && (wave_mode_sel == 4'h9 || wave_mode_sel == 4'hB); // RULE_09
              if (chan_ovr[ch] && chan_match[ch])
                next_wave[ch] = !cur;
            end
            else if (act[1] && chan_match[ch])
              next_wave[ch] = act[0] ^ next_down; // RULE_10
          end
        endcase
      end
      // pad follows waveform only with override; driver enable follows direction alone
      assign pad_out[ch] = chan_ovr[ch] ? cur : port_out[ch]; // RULE_03
      assign pad_oe[ch] = pin_dir[ch]; // RULE_04
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end
    else
    begin
      wave_out_a <= next_wave[0];
      wave_out_b <= next_wave[1];
    end
  end

  // ahb-lite address phase capture; zero-wait, always okay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_cnt = dp_valid && dp_write && dp_addr == `TMWF_ADDR_CNT;
  assign irq_clr = (dp_valid && dp_write && dp_addr == `TMWF_ADDR_IRQ_CLR) ? hwdata[2:0] : 3'h0;

  // register writes; compare buffers load into active values per mode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waveform_control_a <= `TMWF_RST_CTRL_A;
      waveform_control_b <= `TMWF_RST_CTRL_B;
      cmp_buf_a <= 16'h0000;
      cmp_buf_b <= 16'h0000;
      capture_value <= 16'h0000;
      irq_enable <= 3'h0;
      pin_dir <= 2'h0;
    end
    else if (dp_valid && dp_write)
    begin
      case (dp_addr)
        `TMWF_ADDR_CTRL_A: waveform_control_a <= hwdata[7:0] & `TMWF_CTRL_A_MASK; // RULE_18
        `TMWF_ADDR_CTRL_B: waveform_control_b <= hwdata[7:0] & `TMWF_CTRL_B_MASK;
        `TMWF_ADDR_CMP_A: cmp_buf_a <= hwdata[15:0];
        `TMWF_ADDR_CMP_B: cmp_buf_b <= hwdata[15:0];
        `TMWF_ADDR_CAPT: capture_value <= hwdata[15:0];
        `TMWF_ADDR_IRQ_EN: irq_enable <= hwdata[2:0];
        `TMWF_ADDR_PIN_DIR: pin_dir <= hwdata[1:0];
        default: pin_dir <= pin_dir;
      endcase
    end
  end

  // active compare values: immediate in non-pwm, else at the mode's load point
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_value_a <= 16'h0000;
      compare_value_b <= 16'h0000;
    end
    else if (family == TMWF_NORMAL || load_now) // RULE_12
    begin
      compare_value_a <= cmp_buf_a;
      compare_value_b <= cmp_buf_b;
    end
  end

  // sticky flags; a set in the clear cycle wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= 3'h0;
    else
    begin
      irq_status <= (irq_status & ~irq_clr) |
        {match_b, match_a, ovf_event}; // RULE_17
    end
  end
  assign irq = |(irq_status & irq_enable);

  // read mux
  always_comb
  begin
    case (dp_addr)
      `TMWF_ADDR_CTRL_A: hrdata = {24'h000000, waveform_control_a};
      `TMWF_ADDR_CTRL_B: hrdata = {24'h000000, waveform_control_b};
      `TMWF_ADDR_CNT: hrdata = {16'h0000, counter_value};
      `TMWF_ADDR_CMP_A: hrdata = {16'h0000, cmp_buf_a};
      `TMWF_ADDR_CMP_B: hrdata = {16'h0000, cmp_buf_b};
      `TMWF_ADDR_CAPT: hrdata = {16'h0000, capture_value};
      `TMWF_ADDR_IRQ_STAT: hrdata = {29'h00000000, irq_status};
      `TMWF_ADDR_IRQ_EN: hrdata = {29'h00000000, irq_enable};
      `TMWF_ADDR_PIN_DIR: hrdata = {30'h00000000, pin_dir};
      default: hrdata = 32'h00000000;
    endcase
  end
endmodule // tmwf_timer
`default_nettype wire

// >>> hw/tmwf_consts.svh
`ifndef TMWF_CONSTS_SVH
`define TMWF_CONSTS_SVH
// register byte addresses
`define TMWF_ADDR_CTRL_A 8'h80
`define TMWF_ADDR_CTRL_B 8'h84
`define TMWF_ADDR_CNT 8'h88
`define TMWF_ADDR_CMP_A 8'h8C
`define TMWF_ADDR_CMP_B 8'h90
`define TMWF_ADDR_CAPT 8'h94
`define TMWF_ADDR_IRQ_STAT 8'h98
`define TMWF_ADDR_IRQ_CLR 8'h9C
`define TMWF_ADDR_IRQ_EN 8'hA0
`define TMWF_ADDR_PIN_DIR 8'hA4
// reset values
`define TMWF_RST_CTRL_A 8'h00
`define TMWF_RST_CTRL_B 8'h00
// field masks
`define TMWF_CTRL_A_MASK 8'hF3
`define TMWF_CTRL_B_MASK 8'h1F
// fixed tops and max
`define TMWF_TOP_8 16'h00FF
`define TMWF_TOP_9 16'h01FF
`define TMWF_TOP_10 16'h03FF
`define TMWF_MAX 16'hFFFF
`define TMWF_BOTTOM 16'h0000
// prescale divisions, as terminal counts of a 10-bit prescaler
`define TMWF_DIV8_MASK 10'h007
`define TMWF_DIV64_MASK 10'h03F
`define TMWF_DIV256_MASK 10'h0FF
`define TMWF_DIV1024_MASK 10'h3FF
// status bit positions
`define TMWF_IRQ_OVF 0
`define TMWF_IRQ_CMPA 1
`define TMWF_IRQ_CMPB 2
`endif

// >>> hw/tmwf_pkg.sv
package tmwf_pkg;
  // count-sequence families
  typedef enum logic [1:0] {TMWF_NORMAL, TMWF_FAST, TMWF_DUAL_TOPLOAD, TMWF_DUAL_BOTLOAD} tmwf_family_t;
endpackage

// >>> tb/tmwf_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module tmwf_pin_load (
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe,
  output logic [1:0] pin
);
  // the pins carry pull-ups, so a pad that nobody drives reads high
  assign pin = (pad_out & pad_oe) | ~pad_oe;
endmodule // tmwf_pin_load
`default_nettype wire

// >>> tb/tmwf_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmwf_timer_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] port_out,
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe,
  input wire logic irq
);
  logic dp, dpw;
  logic [7:0] dpa, ctla;
  logic [2:0] en, cs;
  logic [1:0] dir;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // shadow copies of the registers, taken at the end of each write data phase
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dp <= 1'b0;
      dpw <= 1'b0;
      dpa <= 8'h00;
      ctla <= 8'h00;
      en <= 3'h0;
      cs <= 3'h0;
      dir <= 2'h0;
    end
    else
    begin
      dp <= hsel & htrans[1] & hready;
      dpw <= hwrite;
      dpa <= haddr;
      if (dp && dpw && dpa == 8'h80) ctla <= hwdata[7:0] & 8'hF3;
      if (dp && dpw && dpa == 8'h84) cs <= hwdata[2:0];
      if (dp && dpw && dpa == 8'hA0) en <= hwdata[2:0];
      if (dp && dpw && dpa == 8'hA4) dir <= hwdata[1:0];
    end
  end
  sequence s_rd(a);
    dp && !dpw && dpa == a;
  endsequence
  // a stopped timer must leave waveform a alone while its clear or set action drives the pin, once the tick pipe is empty
  sequence s_stopped;
    (cs == 3'h0 && ctla[7])[*4];
  endsequence
  a_ctla_readback: assert property (s_rd(8'h80) |-> hrdata == {24'h0, ctla})
    else $error("control a readback wrong");
  a_ctlb_unused: assert property (s_rd(8'h84) |-> hrdata[31:5] == 27'h0)
    else $error("control b unused bits set");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_pin_port_a: assert property (ctla[7:6] == 2'h0 |-> pad_out[0] == port_out[0])
    else $error("pin a not port data");
  a_pin_port_b: assert property (ctla[5:4] == 2'h0 |-> pad_out[1] == port_out[1])
    else $error("pin b not port data");
  a_dir_drive: assert property (pad_oe == dir)
    else $error("driver enable differs from direction");
  a_irq_masked: assert property ((en == 3'h0)[*2] |-> !irq)
    else $error("irq while all enables off");
  a_stop_frozen: assert property (s_stopped |-> $stable(pad_out[0]))
    else $error("wave moved with timer stopped");
endmodule // tmwf_timer_props
bind tmwf_timer tmwf_timer_props u_props (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .port_out, .pad_out, .pad_oe, .irq);
`default_nettype wire

// >>> tb/tmwf_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %h want %h", $time, g, e); \
    end \
  end
module tmwf_timer_tb_top
  import tmwf_pkg::*;
;
  logic clock = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_clock_pin = 1'b0, rd_dp = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, port_out = 2'h0, pad_out, pad_oe, pin;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, d;
  logic hreadyout, hresp, irq;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] acts[4] = '{8'hF0, 8'hA0, 8'h50, 8'h50};
  logic [1:0] wants[4] = '{2'h3, 2'h0, 2'h3, 2'h0};
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #4 clock = ~clock;
  tmwf_timer DUT (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .ext_clock_pin, .port_out, .pad_out, .pad_oe, .irq);
  tmwf_pin_load u_pins (.pad_out, .pad_oe, .pin);
  task stop_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // read data is judged mid data phase, against the oldest noted expectation
  always @(posedge clock) rd_dp <= hsel & htrans[1] & hreadyout & ~hwrite;
  always @(negedge clock)
  begin
    if (rd_dp)
    begin
      `CHK(hrdata & msk_q[0], exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1 && ++k < 50);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clock); while (hreadyout !== 1'b1 && ++k < 50);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(a, 1'b0, 32'h0);
  endtask
  // counter preset, then run at full rate for n cycles and stop again
  task run(input logic [7:0] b, input logic [15:0] c, input int n);
    wr(8'h88, {16'h0, c});
    wr(8'h84, {24'h0, b | 8'h01});
    repeat (n) @(posedge clock);
    wr(8'h84, {24'h0, b});
  endtask
  task pins(input logic [1:0] e);
    repeat (2) @(negedge clock);
    `CHK(pin, e)
  endtask
  task lvl(input logic e);
    repeat (2) @(negedge clock);
    `CHK(irq, e)
  endtask
  initial
  begin
    void'($urandom(37));
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (acts[i]) rd(8'h80 + 8'(i * 4), 32'h0);
    rd(8'hB0, 32'h0);
    repeat (4)
    begin
      d = $urandom;
      wr(8'h80, d);
      rd(8'h80, d & 32'hF3);
      wr(8'h84, d);
      rd(8'h84, d & 32'h1F);
    end
    wr(8'h84, 32'h0);
    wr(8'h80, 32'h0);
    port_out <= 2'($urandom);
    pins(2'h3);
    wr(8'hA4, 32'h3);
    pins(port_out);
    // external clock on rising edges only
    wr(8'h88, 32'h0);
    wr(8'h84, 32'h7);
    repeat (10)
    begin
      ext_clock_pin <= ~ext_clock_pin;
      repeat (4) @(posedge clock);
    end
    rd(8'h88, 32'h5, 32'hFFFF);
    wr(8'h84, 32'h0);
    wr(8'h8C, 32'h3);
    wr(8'h90, 32'h6);
    wr(8'h9C, 32'h7);
    foreach (acts[i])
    begin
      wr(8'h80, {24'h0, acts[i]});
      run(8'h00, 16'h0, 20);
      pins(wants[i]);
    end
    rd(8'h98, 32'h6);
    lvl(1'b0);
    wr(8'hA0, 32'h2);
    lvl(1'b1);
    wr(8'h9C, 32'h6);
    lvl(1'b0);
    // fast pwm 8-bit: toggle action leaves the pin to the port
    wr(8'h84, 32'h8);
    wr(8'h80, 32'h45);
    pins(port_out);
    wr(8'h8C, 32'h10);
    wr(8'h80, 32'h81);
    run(8'h08, 16'hF0, 18);
    pins({port_out[1], 1'b1});
    rd(8'h98, 32'h1, 32'h1);
    wr(8'h84, 32'h9);
    repeat (20) @(posedge clock);
    wr(8'h84, 32'h8);
    pins({port_out[1], 1'b0});
    rd(8'h98, 32'h3, 32'h3);
    // phase correct 8-bit: buffer loads at top, set on the way down
    wr(8'h8C, 32'hF8);
    wr(8'h9C, 32'h7);
    run(8'h00, 16'hF0, 28);
    pins({port_out[1], 1'b1});
    rd(8'h98, 32'h0, 32'h1);
    stop_test();
  end
endmodule // tmwf_timer_tb_top
`default_nettype wire
